// File: src/sps_pkg.sv
// Shared constants, types and helpers of the operator panel status block
package sps_pkg;
	// Register byte addresses
	localparam logic [7:0] A_CTRL  = 8'h00;
	localparam logic [7:0] A_BAND  = 8'h04;
	localparam logic [7:0] A_ROT   = 8'h08;
	localparam logic [7:0] A_TRQ   = 8'h0C;
	localparam logic [7:0] A_INPOS = 8'h10;
	localparam logic [7:0] A_VALUE = 8'h14;
	localparam logic [7:0] A_STAT  = 8'h18;

	// Reset values of the comparison limits
	localparam logic [15:0] BAND_RST  = 16'h000A; // 10 rpm
	localparam logic [15:0] ROT_RST   = 16'h0014; // 20 rpm
	localparam logic [15:0] TRQ_RST   = 16'h000A; // 10 % rated
	localparam logic [15:0] INPOS_RST = 16'h0007; // 7 pulses
	localparam logic [16:0] VALUE_RST = 17'h00000;
	localparam logic [16:0] VALUE_MAX = 17'h1869F; // Five decimal digits

	// Status word field positions
	localparam int unsigned ST_IND  = 0;
	localparam int unsigned ST_CODE = 8;
	localparam int unsigned ST_MODE = 12;
	localparam int unsigned ST_EDIT = 14;
	localparam int unsigned ST_ALM  = 15;
	localparam int unsigned ST_DIG  = 16;

	// Indicator bit positions
	localparam int unsigned IB_CTRL_PWR = 0;
	localparam int unsigned IB_BASEBLK  = 1;
	localparam int unsigned IB_AGREE    = 2; // Speed agree or positioning done
	localparam int unsigned IB_ROTATION = 3;
	localparam int unsigned IB_REF_A    = 4; // Speed ref or reference pulse
	localparam int unsigned IB_REF_B    = 5; // Torque ref or error clear
	localparam int unsigned IB_PWR_RDY  = 6;
	localparam int unsigned IND_W       = 7;

	// Positions of the pins in the synchroniser vector
	localparam int unsigned PI_UP    = 0;
	localparam int unsigned PI_DOWN  = 1;
	localparam int unsigned PI_MODE  = 2;
	localparam int unsigned PI_SHIFT = 3;
	localparam int unsigned PI_ALRST = 4;
	localparam int unsigned PI_FWD   = 5;
	localparam int unsigned PI_REV   = 6;
	localparam int unsigned PIN_W    = 7;

	typedef enum logic [1:0] {
		PM_STATUS  = 2'b00,
		PM_AUX     = 2'b01,
		PM_PARAM   = 2'b10,
		PM_MONITOR = 2'b11
	} sps_pmode_t;

	typedef enum logic [1:0] {
		CM_SPEED    = 2'b00,
		CM_TORQUE   = 2'b01,
		CM_POSITION = 2'b10
	} sps_cmode_t;

	typedef enum logic [2:0] {
		SC_BASEBLOCK = 3'b000,
		SC_RUN       = 3'b001,
		SC_FWD_PROH  = 3'b010,
		SC_REV_PROH  = 3'b011
	} sps_code_t;

	// Drive-internal signals feeding the indicators
	typedef struct packed {
		logic               servo_on;
		logic               main_power_ok;
		logic               ref_pulse_active;
		logic               err_clear_in;
		logic signed [15:0] motor_speed;
		logic signed [15:0] speed_ref;
		logic signed [15:0] torque_ref;
		logic signed [15:0] pos_error;
	} sps_drive_t;

	typedef struct packed {
		logic [15:0] band;
		logic [15:0] rot;
		logic [15:0] trq;
		logic [15:0] inpos;
	} sps_limits_t;

	// Sign extension, so that differences cannot overflow
	function automatic logic signed [16:0] sx(input logic signed [15:0] v);
		return {v[15], v};
	endfunction

	// Magnitude; 17-bit input never reaches its most negative value here
	function automatic logic [16:0] mag(input logic signed [16:0] v);
		return v[16] ? 17'(-v) : 17'(v);
	endfunction
endpackage

// File: src/sps_sync.sv
// Three-stage pin synchroniser with agreement filter and press pulse
module sps_sync #(
	parameter int unsigned W = 1
) (
	input  logic         sys_clk,
	input  logic         rst_n,
	input  logic [W-1:0] din,
	output logic [W-1:0] level,
	output logic [W-1:0] rise
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
		logic [W-1:0] s3;
		logic [W-1:0] lvl;
		logic [W-1:0] rise;
	} sps_sync_st_t;

	sps_sync_st_t q;
	sps_sync_st_t d;

	// Level moves only when stages two and three agree
	always_comb begin
		d = q;
		d.s1 = din;
		d.s2 = q.s1;
		d.s3 = q.s2;
		d.lvl = (~(q.s2 ^ q.s3) & q.s3) | ((q.s2 ^ q.s3) & q.lvl);
		d.rise = d.lvl & ~q.lvl;
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign level = q.lvl;
	assign rise = q.rise;
endmodule // sps_sync

// File: src/sps_ind.sv
// Indicator bit selection and threshold comparison per control mode
module sps_ind (
	input  logic                 ctrl_pwr,
	input  sps_pkg::sps_cmode_t  cmode,
	input  sps_pkg::sps_drive_t  drive,
	input  sps_pkg::sps_limits_t lim,
	output logic [6:0]           ind
);
	logic [16:0] spd_err;
	logic [16:0] spd_mag;
	logic [16:0] ref_mag;
	logic [16:0] trq_mag;
	logic [16:0] pos_mag;

	// Layout depends on control mode; unused code 11 shows speed layout
	always_comb begin
		spd_err = sps_pkg::mag(sps_pkg::sx(drive.motor_speed) - sps_pkg::sx(drive.speed_ref));
		spd_mag = sps_pkg::mag(sps_pkg::sx(drive.motor_speed));
		ref_mag = sps_pkg::mag(sps_pkg::sx(drive.speed_ref));
		trq_mag = sps_pkg::mag(sps_pkg::sx(drive.torque_ref));
		pos_mag = sps_pkg::mag(sps_pkg::sx(drive.pos_error));
		ind = '0;
		ind[sps_pkg::IB_CTRL_PWR] = ctrl_pwr;
		ind[sps_pkg::IB_BASEBLK] = !drive.servo_on;
		ind[sps_pkg::IB_ROTATION] = spd_mag > {1'b0, lim.rot};
		ind[sps_pkg::IB_PWR_RDY] = drive.main_power_ok;
		if (cmode == sps_pkg::CM_POSITION) begin
			ind[sps_pkg::IB_AGREE] = pos_mag < {1'b0, lim.inpos};
			ind[sps_pkg::IB_REF_A] = drive.ref_pulse_active;
			ind[sps_pkg::IB_REF_B] = drive.err_clear_in;
		end else begin
			ind[sps_pkg::IB_AGREE] = (spd_err <= {1'b0, lim.band})
				|| (cmode == sps_pkg::CM_TORQUE);
			ind[sps_pkg::IB_REF_A] = ref_mag > {1'b0, lim.rot};
			ind[sps_pkg::IB_REF_B] = trq_mag > {1'b0, lim.trq};
		end
	end
endmodule // sps_ind

// File: src/sps_panel.sv
// Operator panel top: keys, modes, value editing, alarm and status display
//
// Chosen here: register access over APB and the register offsets.

// Overview of operation
// - Up key while editing a value raises it by the selected digit's weight.
// - Down key while editing a value lowers it by the selected digit's weight.
// - Up and down together in status display mode clear the servo alarm.
// - Each mode key press steps to another of the four top-level modes.
// - Shift key in parameter mode enters data setting, then moves the flashing edit digit.
// - The external alarm reset input also clears the servo alarm.
// - Reset at power-up leaves the latched alarm inactive.
// - After power-up the panel sits in status display mode.
// - Position control uses its own indicator set; speed and torque share one.
// - In torque control the speed agree indicator stays lit.
// - Control power indicator lit whenever the logic is powered and running.
// - Baseblock indicator lit while servo is off, dark when servo is on.
// - Speed agree lit when speed error is within the band, default 10 rpm.
// - Rotation detect lit when motor speed exceeds threshold, default 20 rpm.
// - Speed reference lit when reference exceeds the same rotation threshold.
// - Torque reference lit when reference exceeds level, default ten percent.
// - Power ready indicator follows the main power circuit being normal.
// - Positioning done lit when position error is below in-position width.
// - Reference pulse indicator lit while command pulses arrive.
// - Error counter clear indicator lit while the clear input is asserted.
// - Status code shows baseblock while servo is off, run while on.
// - Status code shows forward or reverse prohibit when overtravel input off.
module sps_panel #(
	parameter int unsigned NUM_DIGITS = 5
) (
	input  logic                sys_clk,
	input  logic                resetn,
	input  logic                psel,
	input  logic                penable,
	input  logic                pwrite,
	input  logic [7:0]          paddr,
	input  logic [31:0]         pwdata,
	output logic [31:0]         prdata,
	output logic                pready,
	output logic                pslverr,
	input  logic                key_up,
	input  logic                key_down,
	input  logic                key_mode,
	input  logic                key_shift,
	input  logic                alarm_reset_in,
	input  logic                fwd_overtravel_in,
	input  logic                rev_overtravel_in,
	input  logic                alarm_event,
	input  sps_pkg::sps_drive_t drive,
	output logic [6:0]          ind_bits,
	output sps_pkg::sps_code_t  status_code,
	output sps_pkg::sps_pmode_t panel_mode,
	output logic                edit_active,
	output logic [2:0]          edit_digit,
	output logic                alarm_active,
	output logic                alarm_cleared
);
	// Digit count must fit the five-digit value range
	if (NUM_DIGITS < 1 || NUM_DIGITS > 5) begin : g_chk
		$error("NUM_DIGITS must be 1 to 5");
	end

	localparam logic [2:0] DIG_LAST = 3'(NUM_DIGITS - 1);

	typedef struct packed {
		logic [31:0]          prdata;
		logic                 pready;
		logic                 pslverr;
		sps_pkg::sps_cmode_t  cmode;
		sps_pkg::sps_limits_t lim;
		logic [16:0]          value;
		sps_pkg::sps_pmode_t  pmode;
		logic                 edit;
		logic [2:0]           digit;
		logic                 alarm;
		logic                 cleared;
		logic [6:0]           ind;
		sps_pkg::sps_code_t   code;
	} sps_state_t;

	localparam sps_state_t Q_RST = '{
		prdata:  32'h0000_0000,
		pready:  1'b0,
		pslverr: 1'b0,
		cmode:   sps_pkg::CM_SPEED,
		lim:     '{band: sps_pkg::BAND_RST, rot: sps_pkg::ROT_RST,
		           trq: sps_pkg::TRQ_RST, inpos: sps_pkg::INPOS_RST},
		value:   sps_pkg::VALUE_RST,
		pmode:   sps_pkg::PM_STATUS,
		edit:    1'b0,
		digit:   3'h0,
		alarm:   1'b0,
		cleared: 1'b0,
		ind:     7'h00,
		code:    sps_pkg::SC_BASEBLOCK
	};

	logic [1:0]  rst_sync_q;
	logic        rst_n;
	logic [6:0]  pin_lvl;
	logic [6:0]  pin_rise;
	logic [6:0]  ind_w;
	sps_state_t  q;
	sps_state_t  d;
	logic        acc_first;
	logic        acc_done;
	logic        addr_hit;
	logic        wr_value;
	logic        combo;
	logic        up_only;
	logic        down_only;
	logic        edit_keys;
	logic        alarm_clr;
	logic [16:0] step;

	// Decimal weight of an edit digit
	function automatic logic [16:0] weight(input logic [2:0] dig);
		case (dig)
			3'h0: return 17'h00001;
			3'h1: return 17'h0000A;
			3'h2: return 17'h00064;
			3'h3: return 17'h003E8;
			default: return 17'h02710;
		endcase
	endfunction

	// Saturating step; stops at the range ends rather than wrapping
	function automatic logic [16:0] bump(input logic [16:0] v, input logic [16:0] w,
	                                     input logic up);
		if (up) begin
			return (v > sps_pkg::VALUE_MAX - w) ? sps_pkg::VALUE_MAX : 17'(v + w);
		end
		return (v < w) ? 17'h00000 : 17'(v - w);
	endfunction

	// Reset release through two flops; assertion stays asynchronous
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			rst_sync_q <= 2'h0;
		end else begin
			rst_sync_q <= {rst_sync_q[0], 1'b1};
		end
	end

	assign rst_n = rst_sync_q[1];

	// All panel pins come from outside the clock domain
	sps_sync #(
		.W (sps_pkg::PIN_W)
	) u_sync (
		.sys_clk (sys_clk),
		.rst_n   (rst_n),
		.din     ({rev_overtravel_in, fwd_overtravel_in, alarm_reset_in,
		            key_shift, key_mode, key_down, key_up}),
		.level   (pin_lvl),
		.rise    (pin_rise)
	);

	// Control power lit once the logic leaves reset
	sps_ind u_ind (
		.ctrl_pwr (rst_n),
		.cmode    (q.cmode),
		.drive    (drive),
		.lim      (q.lim),
		.ind      (ind_w)
	);

	// APB phases: answer one cycle after the access phase starts
	assign acc_first = psel && penable && !q.pready;
	assign acc_done = psel && penable && q.pready;
	assign addr_hit = (paddr == sps_pkg::A_CTRL) || (paddr == sps_pkg::A_BAND)
		|| (paddr == sps_pkg::A_ROT) || (paddr == sps_pkg::A_TRQ)
		|| (paddr == sps_pkg::A_INPOS) || (paddr == sps_pkg::A_VALUE)
		|| (paddr == sps_pkg::A_STAT);
	assign wr_value = acc_done && pwrite && (paddr == sps_pkg::A_VALUE);

	// Key decoding; both arrows together never edit the value
	assign combo = pin_lvl[sps_pkg::PI_UP] && pin_lvl[sps_pkg::PI_DOWN]
		&& (pin_rise[sps_pkg::PI_UP] || pin_rise[sps_pkg::PI_DOWN]);
	assign up_only = pin_rise[sps_pkg::PI_UP] && !pin_lvl[sps_pkg::PI_DOWN];
	assign down_only = pin_rise[sps_pkg::PI_DOWN] && !pin_lvl[sps_pkg::PI_UP];
	assign edit_keys = (q.pmode == sps_pkg::PM_PARAM) && q.edit
		&& !pin_rise[sps_pkg::PI_MODE];
	assign alarm_clr = ((q.pmode == sps_pkg::PM_STATUS) && combo)
		|| pin_lvl[sps_pkg::PI_ALRST];
	assign step = weight(q.digit);

	// Next state of the whole block
	always_comb begin
		d = q;
		d.cleared = 1'b0;
		d.pready = acc_first;
		if (acc_first) begin
			d.pslverr = !addr_hit;
			case (paddr)
				sps_pkg::A_CTRL:  d.prdata = {30'h0, q.cmode};
				sps_pkg::A_BAND:  d.prdata = {16'h0, q.lim.band};
				sps_pkg::A_ROT:   d.prdata = {16'h0, q.lim.rot};
				sps_pkg::A_TRQ:   d.prdata = {16'h0, q.lim.trq};
				sps_pkg::A_INPOS: d.prdata = {16'h0, q.lim.inpos};
				sps_pkg::A_VALUE: d.prdata = {15'h0, q.value};
				sps_pkg::A_STAT: begin
					d.prdata = 32'h0000_0000;
					d.prdata[sps_pkg::ST_IND +: 7] = q.ind;
					d.prdata[sps_pkg::ST_CODE +: 3] = q.code;
					d.prdata[sps_pkg::ST_MODE +: 2] = q.pmode;
					d.prdata[sps_pkg::ST_EDIT] = q.edit;
					d.prdata[sps_pkg::ST_ALM] = q.alarm;
					d.prdata[sps_pkg::ST_DIG +: 3] = q.digit;
				end
				default: d.prdata = 32'h0000_0000;
			endcase
		end
		// Writes land at the completing edge only; status is read-only
		if (acc_done && pwrite) begin
			case (paddr)
				sps_pkg::A_CTRL:  d.cmode = sps_pkg::sps_cmode_t'(pwdata[1:0]);
				sps_pkg::A_BAND:  d.lim.band = pwdata[15:0];
				sps_pkg::A_ROT:   d.lim.rot = pwdata[15:0];
				sps_pkg::A_TRQ:   d.lim.trq = pwdata[15:0];
				sps_pkg::A_INPOS: d.lim.inpos = pwdata[15:0];
				sps_pkg::A_VALUE: begin
					d.value = (pwdata[16:0] > sps_pkg::VALUE_MAX) ? sps_pkg::VALUE_MAX
						: pwdata[16:0];
				end
				default: d.value = d.value;
			endcase
		end
		// Mode key steps 00-01-10-11 and wraps; editing ends with it
		if (pin_rise[sps_pkg::PI_MODE]) begin
			d.pmode = sps_pkg::sps_pmode_t'(q.pmode + 2'h1);
			d.edit = 1'b0;
			d.digit = 3'h0;
		end else if ((q.pmode == sps_pkg::PM_PARAM) && pin_rise[sps_pkg::PI_SHIFT]) begin
			if (!q.edit) begin
				d.edit = 1'b1;
				d.digit = 3'h0;
			end else begin
				d.digit = (q.digit >= DIG_LAST) ? 3'h0 : 3'(q.digit + 3'h1);
			end
		end
		// Key edits override a same-cycle bus write to the value
		if (edit_keys && up_only) begin
			d.value = bump(q.value, step, 1'b1);
		end else if (edit_keys && down_only) begin
			d.value = bump(q.value, step, 1'b0);
		end
		// Alarm: a new event beats a clear in the same cycle
		if (alarm_clr) begin
			d.alarm = 1'b0;
			d.cleared = q.alarm;
		end
		if (alarm_event) begin
			d.alarm = 1'b1;
			d.cleared = 1'b0; // Alarm stays set, so no clear pulse
		end
		d.ind = ind_w;
		// Overtravel outranks the run state in the code field
		if (!pin_lvl[sps_pkg::PI_FWD]) begin
			d.code = sps_pkg::SC_FWD_PROH;
		end else if (!pin_lvl[sps_pkg::PI_REV]) begin
			d.code = sps_pkg::SC_REV_PROH;
		end else if (drive.servo_on) begin
			d.code = sps_pkg::SC_RUN;
		end else begin
			d.code = sps_pkg::SC_BASEBLOCK;
		end
	end

	// Power-up reset puts the panel in status mode with no alarm
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			q <= Q_RST;
		end else begin
			q <= d;
		end
	end

	assign prdata = q.prdata;
	assign pready = q.pready;
	assign pslverr = q.pslverr;
	assign ind_bits = q.ind;
	assign status_code = q.code;
	assign panel_mode = q.pmode;
	assign edit_active = q.edit;
	assign edit_digit = q.digit;
	assign alarm_active = q.alarm;
	assign alarm_cleared = q.cleared;

	default clocking cb @(posedge sys_clk);
	endclocking

	default disable iff (!rst_n);

	sequence s_combo_press;
		q.alarm && (q.pmode == sps_pkg::PM_STATUS) && combo && !alarm_event;
	endsequence

	sequence s_alarm_gone;
		!q.alarm && q.cleared;
	endsequence

	sequence s_inc_press;
		edit_keys && up_only && !wr_value && (q.value < sps_pkg::VALUE_MAX);
	endsequence

	sequence s_dec_press;
		edit_keys && down_only && !wr_value && (q.value != 17'h00000);
	endsequence

	a_value_inc: assert property (s_inc_press |=> q.value > $past(q.value))
		else $error("value did not rise on up key");

	a_value_dec: assert property (s_dec_press |=> q.value < $past(q.value))
		else $error("value did not fall on down key");

	a_combo_reset: assert property (s_combo_press |=> s_alarm_gone)
		else $error("key combination did not clear alarm");

	a_mode_cycle: assert property (pin_rise[sps_pkg::PI_MODE]
		|=> q.pmode == sps_pkg::sps_pmode_t'($past(q.pmode) + 2'h1) && !q.edit)
		else $error("mode key did not step the mode");

	a_mode_wrap: assert property ((q.pmode == sps_pkg::PM_MONITOR)
		&& pin_rise[sps_pkg::PI_MODE] |=> q.pmode == sps_pkg::PM_STATUS)
		else $error("mode did not wrap to status display");

	a_shift_enter: assert property ((q.pmode == sps_pkg::PM_PARAM) && !q.edit
		&& pin_rise[sps_pkg::PI_SHIFT] && !pin_rise[sps_pkg::PI_MODE]
		|=> q.edit && (q.digit == 3'h0))
		else $error("shift key did not enter data setting");

	a_pin_reset: assert property (pin_lvl[sps_pkg::PI_ALRST] && !alarm_event
		|=> !q.alarm)
		else $error("alarm reset input did not clear alarm");

	a_set_wins: assert property (alarm_event |=> q.alarm)
		else $error("alarm event lost");

	a_boot_clean: assert property ($rose(rst_n)
		|-> !q.alarm && (q.pmode == sps_pkg::PM_STATUS) && !q.edit)
		else $error("panel not clean after reset");

	a_torque_lit: assert property ((q.cmode == sps_pkg::CM_TORQUE)
		|=> q.ind[sps_pkg::IB_AGREE])
		else $error("torque mode indicator not lit");

	a_ctrl_power: assert property (rst_n |=> q.ind[sps_pkg::IB_CTRL_PWR])
		else $error("control power indicator dark");

	a_baseblock: assert property (drive.servo_on
		|=> !q.ind[sps_pkg::IB_BASEBLK] && $past(drive.servo_on))
		else $error("baseblock lit with servo on");

	a_pwr_ready: assert property ($past(rst_n)
		|-> q.ind[sps_pkg::IB_PWR_RDY] == $past(drive.main_power_ok))
		else $error("power ready does not follow main power");

	a_pos_pulse: assert property ((q.cmode == sps_pkg::CM_POSITION)
		|=> q.ind[sps_pkg::IB_REF_A] == $past(drive.ref_pulse_active))
		else $error("reference pulse indicator wrong");

	a_code_run: assert property (pin_lvl[sps_pkg::PI_FWD]
		&& pin_lvl[sps_pkg::PI_REV] && drive.servo_on
		|=> q.code == sps_pkg::SC_RUN)
		else $error("run code missing with servo on");

	a_code_fwd: assert property (!pin_lvl[sps_pkg::PI_FWD]
		|=> q.code == sps_pkg::SC_FWD_PROH)
		else $error("forward prohibit code missing");

	a_apb_answer: assert property (acc_first |=> q.pready ##1 !q.pready)
		else $error("APB answer not one cycle");
endmodule // sps_panel

// File: tb/sps_operator.sv
// Operator model that presses and releases the panel keys
module sps_operator (
	input  logic sys_clk,
	output logic key_up,
	output logic key_down,
	output logic key_mode,
	output logic key_shift
);
	timeunit 1ns;
	timeprecision 1ps;

	// A released key reads as not pressed
	initial begin
		{key_shift, key_mode, key_down, key_up} = 4'h0;
	end

	// Keys in order shift, mode, down, up; held past the pin filter, then a quiet gap
	task automatic press(input logic [3:0] k);
		{key_shift, key_mode, key_down, key_up} <= k;
		repeat (6) @(posedge sys_clk);
		{key_shift, key_mode, key_down, key_up} <= 4'h0;
		repeat (8) @(posedge sys_clk);
	endtask
endmodule // sps_operator

// File: tb/testbench.sv
// Self-checking bench of the operator panel status block
module testbench;
	timeunit 1ns;
	timeprecision 1ps;

	logic                sys_clk = 1'b0;
	logic                resetn;
	logic                psel;
	logic                penable;
	logic                pwrite;
	logic [7:0]          paddr;
	logic [31:0]         pwdata;
	logic [31:0]         prdata;
	logic                pready;
	logic                pslverr;
	logic                key_up;
	logic                key_down;
	logic                key_mode;
	logic                key_shift;
	logic                alarm_reset_in;
	logic                fwd_overtravel_in;
	logic                rev_overtravel_in;
	logic                alarm_event;
	sps_pkg::sps_drive_t drive;
	logic [6:0]          ind_bits;
	sps_pkg::sps_code_t  status_code;
	sps_pkg::sps_pmode_t panel_mode;
	logic                edit_active;
	logic [2:0]          edit_digit;
	logic                alarm_active;
	logic                alarm_cleared;
	logic [31:0]         rd;
	logic                er;
	int                  mismatches = 0;
	int                  samples_checked = 0;
	int                  cleared_seen = 0;

	// Free-running 100 MHz clock
	always #5 sys_clk = ~sys_clk;

	sps_operator op_u (
		.sys_clk   (sys_clk),
		.key_up    (key_up),
		.key_down  (key_down),
		.key_mode  (key_mode),
		.key_shift (key_shift)
	);

	sps_panel dut_u (
		.sys_clk           (sys_clk),
		.resetn            (resetn),
		.psel              (psel),
		.penable           (penable),
		.pwrite            (pwrite),
		.paddr             (paddr),
		.pwdata            (pwdata),
		.prdata            (prdata),
		.pready            (pready),
		.pslverr           (pslverr),
		.key_up            (key_up),
		.key_down          (key_down),
		.key_mode          (key_mode),
		.key_shift         (key_shift),
		.alarm_reset_in    (alarm_reset_in),
		.fwd_overtravel_in (fwd_overtravel_in),
		.rev_overtravel_in (rev_overtravel_in),
		.alarm_event       (alarm_event),
		.drive             (drive),
		.ind_bits          (ind_bits),
		.status_code       (status_code),
		.panel_mode        (panel_mode),
		.edit_active       (edit_active),
		.edit_digit        (edit_digit),
		.alarm_active      (alarm_active),
		.alarm_cleared     (alarm_cleared)
	);

	// Clear pulses are single cycles, so they are counted as they pass
	always @(posedge sys_clk) begin
		if (alarm_cleared === 1'b1)
			cleared_seen++;
	end

	task automatic complete_run();
		$display("checks %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		samples_checked++;
		if (got !== exp) begin
			mismatches++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask

	// One APB transfer; the edge after release keeps a strobe from being set twice at once
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge sys_clk);
		penable <= 1'b1;
		// Only the watchdog ends a wait that never completes
		do begin
			@(posedge sys_clk);
		end while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge sys_clk);
	endtask

	task automatic do_reset();
		resetn <= 1'b0;
		repeat (3) @(posedge sys_clk);
		resetn <= 1'b1;
		repeat (6) @(posedge sys_clk);
	endtask

	task automatic raise_alarm();
		alarm_event <= 1'b1;
		@(posedge sys_clk);
		alarm_event <= 1'b0;
		@(posedge sys_clk);
		chk("alarm set", 32'h00000001, alarm_active);
	endtask

	// Control mode, flags (servo on, main power, ref pulse, clear), drive values, expectations
	task automatic ind_case(input logic [1:0] cm, input logic [3:0] fl,
			input logic signed [15:0] ms,
			input logic signed [15:0] sr, input logic signed [15:0] tq,
			input logic signed [15:0] pe, input logic [6:0] ei, input logic [2:0] ecode);
		apb(1'b1, sps_pkg::A_CTRL, {30'h0, cm});
		drive <= '{fl[3], fl[2], fl[1], fl[0], ms, sr, tq, pe};
		repeat (3) @(posedge sys_clk);
		chk("indicators", ei, ind_bits);
		chk("status code", ecode, status_code);
	endtask

	// Hang guard, far beyond the few hundred cycles of the sequence
	initial begin
		repeat (20000) @(posedge sys_clk);
		mismatches++;
		complete_run();
	end

	initial begin
		// Pins idle: keys up, travel allowed, no alarm, bus quiet
		resetn = 1'b0;
		{psel, penable, pwrite} = 3'h0;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
		{alarm_reset_in, alarm_event} = 2'h0;
		{fwd_overtravel_in, rev_overtravel_in} = 2'h3;
		drive = '0;
		do_reset();
		chk("mode after reset", sps_pkg::PM_STATUS, panel_mode);
		chk("alarm after reset", 32'h00000000, alarm_active);
		chk("ctrl power", 32'h00000001, ind_bits[0]);
		apb(1'b0, sps_pkg::A_BAND, 32'h00000000);
		chk("band", sps_pkg::BAND_RST, rd);
		apb(1'b0, sps_pkg::A_ROT, 32'h00000000);
		chk("rotation", sps_pkg::ROT_RST, rd);
		apb(1'b0, sps_pkg::A_TRQ, 32'h00000000);
		chk("torque level", sps_pkg::TRQ_RST, rd);
		apb(1'b0, sps_pkg::A_INPOS, 32'h00000000);
		chk("in position", sps_pkg::INPOS_RST, rd);
		apb(1'b0, 8'h40, 32'h00000000);
		chk("unmapped error", 32'h00000001, er);
		chk("unmapped data", 32'h00000000, rd);
		// Full cycle of modes, ending back at status display
		for (int i = 1; i <= 4; i++) begin
			op_u.press(4'h4);
			chk("mode step", 32'(i % 4), panel_mode);
		end
		// Data setting in parameter mode
		op_u.press(4'h4);
		op_u.press(4'h4);
		op_u.press(4'h8);
		chk("edit on", 32'h00000001, edit_active);
		chk("edit digit", 32'h00000000, edit_digit);
		op_u.press(4'h1);
		op_u.press(4'h8);
		chk("edit digit", 32'h00000001, edit_digit);
		op_u.press(4'h1);
		apb(1'b0, sps_pkg::A_VALUE, 32'h00000000);
		chk("value raised", 32'h0000000B, rd);
		op_u.press(4'h2);
		op_u.press(4'h3);
		apb(1'b0, sps_pkg::A_VALUE, 32'h00000000);
		chk("value lowered", 32'h00000001, rd);
		op_u.press(4'h4);
		chk("edit off", 32'h00000000, edit_active);
		op_u.press(4'h4);
		// Alarm cleared by key pair, by the pin, and by power loss
		raise_alarm();
		op_u.press(4'h3);
		chk("alarm key clear", 32'h00000000, alarm_active);
		raise_alarm();
		alarm_reset_in <= 1'b1;
		repeat (8) @(posedge sys_clk);
		alarm_reset_in <= 1'b0;
		repeat (4) @(posedge sys_clk);
		chk("alarm pin clear", 32'h00000000, alarm_active);
		chk("clear pulses", 32'h00000002, cleared_seen);
		raise_alarm();
		do_reset();
		chk("alarm power loss", 32'h00000000, alarm_active);
		// Speed, torque and position indicator sets at their thresholds
		ind_case(2'b00, 4'h0, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 7'h07, 3'h0);
		ind_case(2'b00, 4'hC, 16'h0014, 16'h000A, 16'h000A, 16'h0000, 7'h45, 3'h1);
		ind_case(2'b00, 4'hC, 16'h0015, 16'h000A, 16'h000B, 16'h0000, 7'h69, 3'h1);
		ind_case(2'b00, 4'hC, 16'h0015, 16'h0015, 16'h0000, 16'h0000, 7'h5D, 3'h1);
		ind_case(2'b00, 4'hC, 16'hFFEB, 16'h0000, 16'h0000, 16'h0000, 7'h49, 3'h1);
		ind_case(2'b01, 4'hC, 16'h0015, 16'h000A, 16'h000B, 16'h0000, 7'h6D, 3'h1);
		ind_case(2'b11, 4'hC, 16'h0015, 16'h000A, 16'h000B, 16'h0000, 7'h69, 3'h1);
		ind_case(2'b10, 4'hE, 16'h0000, 16'h0000, 16'h0000, 16'h0006, 7'h55, 3'h1);
		ind_case(2'b10, 4'hD, 16'h0000, 16'h0015, 16'h000B, 16'h0007, 7'h61, 3'h1);
		// Overtravel pins take over the code
		fwd_overtravel_in <= 1'b0;
		repeat (8) @(posedge sys_clk);
		chk("fwd prohibit", sps_pkg::SC_FWD_PROH, status_code);
		fwd_overtravel_in <= 1'b1;
		rev_overtravel_in <= 1'b0;
		repeat (8) @(posedge sys_clk);
		chk("rev prohibit", sps_pkg::SC_REV_PROH, status_code);
		rev_overtravel_in <= 1'b1;
		repeat (8) @(posedge sys_clk);
		chk("run again", sps_pkg::SC_RUN, status_code);
		complete_run();
	end
endmodule // testbench
